// File: common/fpb_defines.vh
// fpb_defines.vh: register offsets, command codes, buffer sizes and field limits
// for the fic/pad buffer access block; included by the design files.
`ifndef FPB_DEFINES_VH
`define FPB_DEFINES_VH

// apb register byte offsets
`define FPB_OFF_CMD 12'h000
`define FPB_OFF_DATA 12'h004
`define FPB_OFF_RESP 12'h008
`define FPB_OFF_STAT 12'h00c

// command codes
`define FPB_CMD_SET_FIG 8'h60
`define FPB_CMD_GET_FIG 8'h61
`define FPB_CMD_GET_FPAD 8'h62
`define FPB_CMD_SET_XPAD 8'h63
`define FPB_CMD_GET_XPAD 8'h64
`define FPB_CMD_GET_MS 8'h65
`define FPB_CMD_CLR_FIG 8'h6a
`define FPB_CMD_CLR_PAD 8'h6b

// buffer geometry
`define FPB_BUF_BYTES 12'h800
`define FPB_FPAD_DEPTH 6'd40
`define FPB_PAIRS_MAX 7'd127
`define FPB_FIG_MAX 8'd30
`define FPB_XPAD_MAX 8'hff
`define FPB_FIG_MARGIN 12'h020
`define FPB_XPAD_MARGIN 12'h100

// application type coding
`define FPB_WIDEN_BASE 9'd31
`define FPB_APP_TYPE_LAST 9'd286
`define FPB_OV_BIT 4

`endif

// File: design/fpb_core.v
// fpb_core.v: fic/pad capture buffers, filters and command interpreter behind apb.
// assumes decoder capture strobes and the apb master are synchronous to pclk.
//
// What this block does
// - buffers keep arrival order; when full, oldest record is discarded first
// - fig and x-pad buffers are 2 kbytes circular; f-pad holds 40 entries
// - command 60 replaces the filter of fig type in bits 2:0
// - each fig type has its own list of up to 127 mask/match pairs
// - fig kept when (first data byte & mask) equals match for any pair
// - new filter list for one type leaves other types' lists untouched
// - after reset every type 0 fig is wanted
// - command 61 returns next wanted fig, up to 30 bytes, or nothing
// - command 62 returns next f-pad entry, byte l then l-1, or nothing
// - pad access on a channel without mpeg decoding flags a command error
// - command 63: bit 7 widen, bit 6 add/remove, bits 5:0 channel
// - type byte is 0-255, or 31 plus byte when widened
// - no x-pad type wanted after reset; any set may be added
// - command 64 returns oldest wanted x-pad: two header bytes plus data
// - x-pad header: ci bit 7, kind bits 6:5, 9-bit type in bit 0 and byte 2
// - header bit 4 set when x-pad buffer lost older data
// - command 65 returns music/speech flags in bits 1:0
// - flags request on a non-mpeg channel flags a command error
`timescale 1ns/1ps
`include "fpb_defines.vh"

module fpb_core (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// channel configuration
	input wire mpeg_chan_en,
	input wire mpeg_chan,
	input wire [1:0] music_speech_flags,
	// fig capture
	input wire fig_start,
	input wire [2:0] fig_type_select,
	input wire fig_valid,
	input wire [7:0] fig_byte,
	input wire fig_end,
	// f-pad capture
	input wire fpad_valid,
	input wire [15:0] fpad_word,
	// x-pad capture
	input wire xpad_start,
	input wire contents_indicator,
	input wire [1:0] xpad_kind,
	input wire [8:0] xpad_app_type,
	input wire xpad_valid,
	input wire [7:0] xpad_byte,
	input wire xpad_end
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_COPY = 2'b10;

	function chan_ok;
		input en;
		input ch;
		input [7:0] d;
		begin
			chan_ok = en && (d[5:0] == {5'h00, ch});
		end
	endfunction

	function [5:0] inc40;
		input [5:0] p;
		begin
			inc40 = (p == `FPB_FPAD_DEPTH - 6'd1) ? 6'd0 : p + 6'd1;
		end
	endfunction

	function mapped;
		input [11:0] a;
		begin
			mapped = (a == `FPB_OFF_CMD) || (a == `FPB_OFF_DATA) ||
				(a == `FPB_OFF_RESP) || (a == `FPB_OFF_STAT);
		end
	endfunction

	// apb handshake
	reg ack;
	wire apb_done = psel & penable & ack & ce;
	assign pready = ack & ce;
	assign pslverr = pready & ~mapped(paddr);

	// command engine state
	reg [1:0] st;
	reg [7:0] cmd;
	reg [8:0] argn;
	reg [7:0] arg0;
	reg [7:0] fmask;
	reg [2:0] ftype;
	reg cmd_err;
	reg cp_sel;
	reg cp_first;
	reg [10:0] cp_addr;
	reg [7:0] cp_left;
	reg [7:0] resp_mem [0:255];
	reg [8:0] resp_len;
	reg [8:0] resp_idx;
	wire cp_busy = (st == ST_COPY);

	// fig filter state
	reg [15:0] filt [0:1023];
	reg [6:0] filt_cnt [0:7];
	reg dflt0;
	reg sc_busy;
	reg sc_hit;
	reg [2:0] sc_type;
	reg [7:0] sc_ext;
	reg [6:0] sc_idx;

	// x-pad wanted sets, one per channel
	reg [286:0] want [0:1];

	// f-pad ring
	reg [15:0] fpad_mem [0:39];
	reg [5:0] fp_rd;
	reg [5:0] fp_wr;
	reg [5:0] fp_cnt;

	// apb decode
	wire [7:0] d = pwdata[7:0];
	wire wr_cmd = apb_done & pwrite & (paddr == `FPB_OFF_CMD) & ~cp_busy;
	wire wr_data = apb_done & pwrite & (paddr == `FPB_OFF_DATA) & ~cp_busy;
	wire rd_resp = apb_done & ~pwrite & (paddr == `FPB_OFF_RESP);
	wire resp_avail = resp_idx < resp_len;
	wire first = (argn == 9'd0);
	wire dch_ok = chan_ok(mpeg_chan_en, mpeg_chan, d);

	// byte buffers: index 0 fig, index 1 x-pad
	wire [1:0] b_ne;
	wire [1:0] b_lost;
	wire [15:0] b_len;
	wire [15:0] b_rdata;
	wire [23:0] b_rd;
	wire [1:0] b_pop;
	wire [1:0] b_clr;
	wire [1:0] b_lost_clr;
	wire xpad_type_ok = (xpad_app_type <= `FPB_APP_TYPE_LAST);
	wire xpad_keep = mpeg_chan_en & xpad_type_ok & want[mpeg_chan][xpad_app_type];
	wire [1:0] b_start = {xpad_start & xpad_keep, fig_start};
	wire [1:0] b_valid = {xpad_valid, fig_valid};
	wire [15:0] b_byte = {xpad_byte, fig_byte};
	wire [1:0] b_end = {xpad_end, fig_end};
	wire [1:0] b_done = {1'b1, ~sc_busy & ~fig_start};
	wire [1:0] b_keep = {1'b1, sc_hit};
	wire [7:0] xp_h1 = {contents_indicator, xpad_kind, 4'h0, xpad_app_type[8]};
	wire [7:0] xp_h2 = xpad_app_type[7:0];

	// command executions
	wire fig_get = wr_cmd & (d == `FPB_CMD_GET_FIG) & b_ne[0];
	wire fpad_get = wr_data & (cmd == `FPB_CMD_GET_FPAD) & first & dch_ok &
		(fp_cnt != 6'd0);
	wire xpad_get = wr_data & (cmd == `FPB_CMD_GET_XPAD) & first & dch_ok & b_ne[1];
	wire pad_clr = wr_data & (cmd == `FPB_CMD_CLR_PAD) & first & dch_ok;
	wire cp_last = cp_busy & (cp_left == 8'd1);

	assign b_pop = {cp_last & cp_sel, cp_last & ~cp_sel};
	assign b_clr = {pad_clr, wr_cmd & (d == `FPB_CMD_CLR_FIG)};
	assign b_lost_clr = {cp_busy & cp_sel & cp_first, 1'b0};

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gbuf
			localparam [11:0] HL = (g == 1) ? 12'd2 : 12'd0;
			localparam [11:0] MARGIN = (g == 1) ? `FPB_XPAD_MARGIN : `FPB_FIG_MARGIN;
			localparam [7:0] MAXLEN = (g == 1) ? `FPB_XPAD_MAX : `FPB_FIG_MAX;
			reg [7:0] mem [0:2047];
			reg [11:0] rd;
			reg [11:0] wc;
			reg [11:0] wp;
			reg act;
			reg ending;
			reg lost;
			wire [11:0] used = wp - rd;
			wire [11:0] free = `FPB_BUF_BYTES - used;
			wire lock = cp_busy & (cp_sel == (g == 1));
			wire ne = (rd != wc);
			// make room for the incoming record by dropping the oldest one
			wire drop = act & (free < MARGIN) & ne & ~lock;
			wire live = act | b_start[g];
			wire [11:0] base = b_start[g] ? wc + 12'd1 + HL : wp;
			wire [11:0] plen = base - wc - 12'd1;
			wire take = b_valid[g] & live & ~ending & (plen < {4'h0, MAXLEN});
			wire full = ((base - rd) >= `FPB_BUF_BYTES);
			wire abort = take & full;
			wire [11:0] next_wp = abort ? wc : (take ? base + 12'd1 : base);
			wire fin = live & ~abort & (ending | b_end[g]) & b_done[g];
			wire commit = fin & b_keep[g] & (next_wp != wc + 12'd1 + HL);
			wire [11:0] rec_len = next_wp - wc - 12'd1;
			wire [11:0] head_skip = {4'h0, mem[rd[10:0]]} + 12'd1;
			assign b_ne[g] = ne;
			assign b_lost[g] = lost;
			assign b_len[g*8 +: 8] = mem[rd[10:0]];
			assign b_rdata[g*8 +: 8] = mem[cp_addr];
			assign b_rd[g*12 +: 12] = rd;

			always @(posedge pclk)
			begin
				if (ce)
				begin
					if (b_start[g] && g == 1)
					begin
						mem[wc[10:0] + 11'd1] <= xp_h1;
						mem[wc[10:0] + 11'd2] <= xp_h2;
					end
					if (take && !full)
						mem[base[10:0]] <= b_byte[g*8 +: 8];
					if (commit)
						mem[wc[10:0]] <= rec_len[7:0];
				end
			end

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					rd <= 12'h000;
					wc <= 12'h000;
					wp <= 12'h000;
					act <= 1'b0;
					ending <= 1'b0;
					lost <= 1'b0;
				end
				else if (ce)
				begin
					if (b_clr[g])
						rd <= wc;
					else if (b_pop[g] || drop)
						rd <= rd + head_skip;
					if (drop || abort)
						lost <= 1'b1;
					else if (b_lost_clr[g])
						lost <= 1'b0;
					if (commit)
						wc <= next_wp;
					wp <= (fin && !commit) ? wc : next_wp;
					act <= live & ~fin & ~abort;
					ending <= live & ~fin & ~abort & (ending | b_end[g]);
				end
			end
		end
	endgenerate

	// fig filter scan, one pair per cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sc_busy <= 1'b0;
			sc_hit <= 1'b0;
			sc_type <= 3'h0;
			sc_ext <= 8'h00;
			sc_idx <= 7'h00;
		end
		else if (ce)
		begin
			if (fig_start)
			begin
				sc_busy <= 1'b1;
				sc_idx <= 7'h00;
				sc_type <= fig_type_select;
				sc_ext <= fig_byte;
				sc_hit <= (fig_type_select == 3'h0) & dflt0;
			end
			else if (sc_busy)
			begin
				if (sc_idx == filt_cnt[sc_type])
					sc_busy <= 1'b0;
				else
				begin
					if ((sc_ext & filt[{sc_type, sc_idx}][15:8]) ==
						filt[{sc_type, sc_idx}][7:0])
						sc_hit <= 1'b1;
					sc_idx <= sc_idx + 7'd1;
				end
			end
		end
	end

	// f-pad ring, overwrites oldest entry when full
	always @(posedge pclk)
	begin
		if (ce && fpad_valid)
			fpad_mem[fp_wr] <= fpad_word;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fp_rd <= 6'd0;
			fp_wr <= 6'd0;
			fp_cnt <= 6'd0;
		end
		else if (ce)
		begin
			if (pad_clr)
			begin
				fp_rd <= fp_wr;
				fp_cnt <= 6'd0;
			end
			else
			begin
				if (fpad_valid)
					fp_wr <= inc40(fp_wr);
				if (fpad_get || (fpad_valid && fp_cnt == `FPB_FPAD_DEPTH))
					fp_rd <= inc40(fp_rd);
				if (fpad_valid && !fpad_get && fp_cnt != `FPB_FPAD_DEPTH)
					fp_cnt <= fp_cnt + 6'd1;
				else if (fpad_get && !fpad_valid)
					fp_cnt <= fp_cnt - 6'd1;
			end
		end
	end

	// response array fill
	always @(posedge pclk)
	begin
		if (ce)
		begin
			if (cp_busy)
				resp_mem[resp_len[7:0]] <= (cp_sel && cp_first) ?
					(b_rdata[15:8] | ({7'h00, b_lost[1]} << `FPB_OV_BIT)) :
					b_rdata[cp_sel*8 +: 8];
			else if (fpad_get)
			begin
				resp_mem[0] <= fpad_mem[fp_rd][15:8];
				resp_mem[1] <= fpad_mem[fp_rd][7:0];
			end
			else if (wr_data && cmd == `FPB_CMD_GET_MS && first && dch_ok)
				resp_mem[0] <= {6'h00, music_speech_flags};
		end
	end

	// command interpreter
	integer i;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= ST_IDLE;
			cmd <= 8'h00;
			argn <= 9'h000;
			arg0 <= 8'h00;
			fmask <= 8'h00;
			ftype <= 3'h0;
			cmd_err <= 1'b0;
			cp_sel <= 1'b0;
			cp_first <= 1'b0;
			cp_addr <= 11'h000;
			cp_left <= 8'h00;
			resp_len <= 9'h000;
			resp_idx <= 9'h000;
			dflt0 <= 1'b1;
			want[0] <= 287'h0;
			want[1] <= 287'h0;
			for (i = 0; i < 8; i = i + 1)
				filt_cnt[i] <= 7'h00;
		end
		else if (ce)
		begin
			if (rd_resp && resp_avail)
				resp_idx <= resp_idx + 9'd1;
			case (st)
				ST_IDLE:
				begin
					if (wr_cmd)
					begin
						cmd <= d;
						argn <= 9'h000;
						cmd_err <= 1'b0;
						resp_len <= 9'h000;
						resp_idx <= 9'h000;
						if (fig_get)
						begin
							st <= ST_COPY;
							cp_sel <= 1'b0;
							cp_first <= 1'b1;
							cp_addr <= b_rd[10:0] + 11'd1;
							cp_left <= b_len[7:0];
						end
						else if (d < `FPB_CMD_SET_FIG || d > `FPB_CMD_CLR_PAD ||
							(d > `FPB_CMD_GET_MS && d < `FPB_CMD_CLR_FIG))
							cmd_err <= 1'b1;
					end
					else if (wr_data)
					begin
						if (argn != 9'h1ff)
							argn <= argn + 9'd1;
						if (first)
							arg0 <= d;
						if (first && cmd != `FPB_CMD_SET_FIG && cmd != `FPB_CMD_GET_FIG &&
							cmd != `FPB_CMD_CLR_FIG && !dch_ok)
							cmd_err <= 1'b1;
						if (cmd == `FPB_CMD_SET_FIG)
						begin
							if (first)
							begin
								ftype <= d[2:0];
								filt_cnt[d[2:0]] <= 7'h00;
								if (d[2:0] == 3'h0)
									dflt0 <= 1'b0;
							end
							else if (argn[0])
								fmask <= d;
							else if (filt_cnt[ftype] != `FPB_PAIRS_MAX)
							begin
								filt[{ftype, filt_cnt[ftype]}] <= {fmask, d};
								filt_cnt[ftype] <= filt_cnt[ftype] + 7'd1;
							end
						end
						if (cmd == `FPB_CMD_SET_XPAD && argn == 9'd1 &&
							chan_ok(mpeg_chan_en, mpeg_chan, arg0))
						begin
							if (arg0[7])
								want[arg0[0]][`FPB_WIDEN_BASE + {1'b0, d}] <= arg0[6];
							else
								want[arg0[0]][{1'b0, d}] <= arg0[6];
						end
						if (fpad_get)
							resp_len <= 9'd2;
						if (cmd == `FPB_CMD_GET_MS && first && dch_ok)
							resp_len <= 9'd1;
						if (xpad_get)
						begin
							st <= ST_COPY;
							cp_sel <= 1'b1;
							cp_first <= 1'b1;
							cp_addr <= b_rd[22:12] + 11'd1;
							cp_left <= b_len[15:8];
						end
					end
				end
				ST_COPY:
				begin
					resp_len <= resp_len + 9'd1;
					cp_addr <= cp_addr + 11'd1;
					cp_left <= cp_left - 8'd1;
					cp_first <= 1'b0;
					if (cp_last)
						st <= ST_IDLE;
				end
				default:
					st <= ST_IDLE;
			endcase
		end
	end

	// apb read data and wait state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack <= 1'b0;
			prdata <= 32'h00000000;
		end
		else if (ce)
		begin
			ack <= psel & penable & ~ack;
			if (psel && penable && !ack)
			begin
				case (paddr)
					`FPB_OFF_CMD: prdata <= {24'h000000, cmd};
					`FPB_OFF_DATA: prdata <= {23'h000000, argn};
					`FPB_OFF_RESP: prdata <= {23'h000000, resp_avail,
						resp_mem[resp_idx[7:0]]};
					`FPB_OFF_STAT: prdata <= {7'h00, resp_len, 2'b00, fp_cnt,
						3'h0, b_ne, resp_avail, cmd_err, cp_busy};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// File: sim/fpb_core_props.sv
// apb-side assertions for fpb_core
// bound into every fpb_core; sees only its ports
`timescale 1ns/1ps
`include "fpb_defines.vh"
module fpb_core_props (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg [7:0] lc;
	wire done = psel && penable && pready;
	wire st = done && !pwrite && paddr == `FPB_OFF_STAT;
	wire bad = paddr > `FPB_OFF_STAT || paddr[1:0] != 2'h0;
	// last command code written
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			lc <= 8'h00;
		else if (done && pwrite && paddr == `FPB_OFF_CMD)
			lc <= pwdata[7:0];
	a_resp_zero: assert property (
		done && !pwrite && paddr == `FPB_OFF_RESP |-> prdata[31:9] == 23'h0)
		else $error("response reserved bits set");
	a_stat_zero: assert property (
		st |-> prdata[31:25] == 7'h0 && prdata[15:14] == 2'h0 && prdata[7:5] == 3'h0)
		else $error("status reserved bits set");
	a_fpad_depth: assert property (
		st |-> prdata[13:8] <= `FPB_FPAD_DEPTH)
		else $error("f-pad count above depth");
	a_fig_len: assert property (
		st && lc == `FPB_CMD_GET_FIG |-> prdata[24:16] <= 9'd30)
		else $error("fig response too long");
	a_fpad_len: assert property (
		st && lc == `FPB_CMD_GET_FPAD |-> prdata[24:16] <= 9'd2)
		else $error("f-pad response too long");
	a_flags_len: assert property (
		st && lc == `FPB_CMD_GET_MS |-> prdata[24:16] <= 9'd1)
		else $error("flags response too long");
	a_ready_wait: assert property (
		psel && !penable ##1 psel && penable && ce ##1 ce |-> pready)
		else $error("pready late");
	a_ready_phase: assert property (
		pready |-> psel && penable && ce)
		else $error("pready outside access");
	a_slverr_map: assert property (
		done |-> pslverr == bad)
		else $error("pslverr wrong for address");
endmodule

bind fpb_core fpb_core_props fpb_core_props_i (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr)
);

// File: sim/fpb_host.sv
// host controller model: apb master and command byte coding
// assumes slave raises pready in the access phase
`timescale 1ns/1ps
module fpb_host (
	// clock
	input wire pclk,
	// apb
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	initial
	begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
	end
	// channel byte, bits 7:6 zero
	function logic [7:0] chb(input logic c);
		chb = {7'h00, c};
	endfunction
	// app type command byte
	function logic [7:0] app(input logic wd, input logic ad, input logic c);
		app = {wd, ad, 5'h00, c};
	endfunction
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] v,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1;
		// judge pready once settled; the transfer ends at the next rising edge
		@(negedge pclk);
		while (pready !== 1'b1)
			@(negedge pclk);
		q = prdata;
		e = pslverr;
		@(posedge pclk);
		psel <= 0;
		penable <= 0;
		// released bus shows no stale value
		paddr <= ~a;
		pwdata <= ~v;
	endtask
endmodule

// File: sim/tb_fpb_core.sv
// self-checking bench for fpb_core
// host model on apb, bench drives capture strobes
`timescale 1ns/1ps
`include "fpb_defines.vh"
module tb_fpb_core;
	logic pclk = 0, presetn = 0, ce = 1, mpeg_chan_en = 1, mpeg_chan = 0;
	logic fig_start = 0, fig_valid = 0, fig_end = 0, fpad_valid = 0;
	logic xpad_start = 0, xpad_valid = 0, xpad_end = 0, contents_indicator = 1;
	logic [1:0] music_speech_flags = 0, xpad_kind = 2'h1;
	logic [2:0] fig_type_select = 0;
	logic [7:0] fig_byte = 0, xpad_byte = 0;
	logic [8:0] xpad_app_type = 0;
	logic [15:0] fpad_word = 0;
	wire psel, penable, pwrite, pready, pslverr;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	int num_errors = 0, n_tests = 0, cyc = 0, seed = 19536;
	logic [31:0] d;
	logic e;
	logic [7:0] x[$], y[$], z[$], g[$];
	logic [15:0] w[41];
	always #25 pclk = ~pclk;
	fpb_core fpb_core_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mpeg_chan_en(mpeg_chan_en),
		.mpeg_chan(mpeg_chan), .music_speech_flags(music_speech_flags),
		.fig_start(fig_start), .fig_type_select(fig_type_select), .fig_valid(fig_valid),
		.fig_byte(fig_byte), .fig_end(fig_end), .fpad_valid(fpad_valid),
		.fpad_word(fpad_word), .xpad_start(xpad_start),
		.contents_indicator(contents_indicator), .xpad_kind(xpad_kind),
		.xpad_app_type(xpad_app_type), .xpad_valid(xpad_valid), .xpad_byte(xpad_byte),
		.xpad_end(xpad_end));
	fpb_host fpb_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	task end_of_test();
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task rd(input logic [11:0] a);
		fpb_host_i.xfer(0, a, 0, d, e);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		fpb_host_i.xfer(1, a, v, d, e);
	endtask
	task send(input [7:0] c, input int n, input [7:0] b0, input [7:0] b1, input [7:0] b2);
		wr(`FPB_OFF_CMD, c);
		if (n > 0)
			wr(`FPB_OFF_DATA, b0);
		if (n > 1)
			wr(`FPB_OFF_DATA, b1);
		if (n > 2)
			wr(`FPB_OFF_DATA, b2);
	endtask
	// run a command, wait while busy, collect response bytes
	task ask(input [7:0] c, input int n, input [7:0] b0);
		send(c, n, b0, 0, 0);
		g = {};
		for (int i = 0; i < 400 && (i == 0 || d[0] !== 1'b0); i++)
			rd(`FPB_OFF_STAT);
		rd(`FPB_OFF_RESP);
		while (d[8] === 1'b1 && g.size() < 300)
		begin
			g.push_back(d[7:0]);
			rd(`FPB_OFF_RESP);
		end
	endtask
	task cmpq(input string nm, input logic [7:0] q[$]);
		chk(nm, q.size(), g.size());
		foreach (q[i])
			if (i < g.size())
				chk(nm, q[i], g[i]);
	endtask
	// fig: a[10:8] type, a[7:0] ext; x-pad: a[8:0] app type
	task cap(input logic xp, input logic [11:0] a, input int n, output logic [7:0] q[$]);
		logic [7:0] b;
		q = {};
		if (xp)
			q = '{{4'ha, 3'h0, a[8]}, a[7:0]};
		for (int i = 0; i < n; i++)
		begin
			@(posedge pclk);
			b = (i == 0 && !xp) ? a[7:0] : $random(seed);
			q.push_back(b);
			fig_start <= !xp && i == 0;
			fig_valid <= !xp;
			fig_type_select <= a[10:8];
			fig_byte <= b;
			fig_end <= !xp && i == n - 1;
			xpad_start <= xp && i == 0;
			xpad_app_type <= a[8:0];
			xpad_valid <= xp;
			xpad_byte <= b;
			xpad_end <= xp && i == n - 1;
		end
		@(posedge pclk);
		{fig_start, fig_valid, fig_end, xpad_start, xpad_valid, xpad_end} <= 6'h00;
		repeat (140) @(posedge pclk);
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		rd(`FPB_OFF_STAT);
		chk("stat", 0, d);
		rd(12'h010);
		chk("slverr", 1, e);
		cap(0, 12'h005, 4, x);
		cap(0, 12'h105, 3, y);
		ask(`FPB_CMD_GET_FIG, 0, 0);
		cmpq("fig0", x);
		ask(`FPB_CMD_GET_FIG, 0, 0);
		cmpq("fig1", z);
		send(`FPB_CMD_SET_FIG, 3, 8'h01, 8'hf0, 8'h30);
		cap(0, 12'h13a, 5, x);
		cap(0, 12'h14a, 2, y);
		cap(0, 12'h011, 3, y);
		ask(`FPB_CMD_GET_FIG, 0, 0);
		cmpq("figm", x);
		ask(`FPB_CMD_GET_FIG, 0, 0);
		cmpq("figo", y);
		ask(`FPB_CMD_GET_FIG, 0, 0);
		cmpq("fige", z);
		wr(`FPB_OFF_CMD, `FPB_CMD_SET_FIG);
		wr(`FPB_OFF_DATA, 8'h02);
		for (int i = 0; i < 128; i++)
		begin
			wr(`FPB_OFF_DATA, 8'hff);
			wr(`FPB_OFF_DATA, i < 126 ? 8'h01 : i == 126 ? 8'h02 : 8'h03);
		end
		cap(0, 12'h202, 2, x);
		cap(0, 12'h203, 2, y);
		ask(`FPB_CMD_GET_FIG, 0, 0);
		cmpq("f127", x);
		ask(`FPB_CMD_GET_FIG, 0, 0);
		cmpq("f128", z);
		for (int i = 0; i < 41; i++)
		begin
			@(posedge pclk);
			w[i] = $random(seed);
			fpad_valid <= 1;
			fpad_word <= w[i];
		end
		@(posedge pclk);
		fpad_valid <= 0;
		ask(`FPB_CMD_GET_FPAD, 1, 8'hc0);
		x = '{w[1][15:8], w[1][7:0]};
		cmpq("fpad", x);
		rd(`FPB_OFF_STAT);
		chk("fcnt", 39, d[13:8]);
		// frozen clock enable: f-pad strobes must not land
		@(posedge pclk);
		ce <= 0;
		fpad_valid <= 1;
		repeat (3) @(posedge pclk);
		ce <= 1;
		fpad_valid <= 0;
		rd(`FPB_OFF_STAT);
		chk("ce", 39, d[13:8]);
		for (int i = 0; i < 4; i++)
		begin
			music_speech_flags <= i[1:0];
			ask(`FPB_CMD_GET_MS, 1, fpb_host_i.chb(0));
			x = '{i[7:0]};
			cmpq("ms", x);
		end
		send(`FPB_CMD_GET_FPAD, 1, fpb_host_i.chb(1), 0, 0);
		rd(`FPB_OFF_STAT);
		chk("ferr", 1, d[1]);
		send(`FPB_CMD_GET_MS, 1, fpb_host_i.chb(1), 0, 0);
		rd(`FPB_OFF_STAT);
		chk("merr", 1, d[1]);
		mpeg_chan_en <= 0;
		send(`FPB_CMD_GET_XPAD, 1, fpb_host_i.chb(0), 0, 0);
		rd(`FPB_OFF_STAT);
		chk("xerr", 1, d[1]);
		mpeg_chan_en <= 1;
		cap(1, 12'h005, 3, y);
		ask(`FPB_CMD_GET_XPAD, 1, 0);
		cmpq("xnone", z);
		send(`FPB_CMD_SET_XPAD, 2, fpb_host_i.app(1, 1, 0), 8'hff, 0);
		cap(1, 12'h11e, 3, x);
		ask(`FPB_CMD_GET_XPAD, 1, 0);
		cmpq("x286", x);
		send(`FPB_CMD_SET_XPAD, 2, fpb_host_i.app(1, 0, 0), 8'hff, 0);
		cap(1, 12'h11e, 2, y);
		ask(`FPB_CMD_GET_XPAD, 1, 0);
		cmpq("xrem", z);
		send(`FPB_CMD_SET_XPAD, 2, fpb_host_i.app(0, 1, 0), 8'h07, 0);
		repeat (12) cap(1, 12'h007, 200, x);
		ask(`FPB_CMD_GET_XPAD, 1, 0);
		chk("ov", 1, g[0][4]);
		chk("ovt", 8'h07, g[1]);
		end_of_test();
	end
endmodule
